// file: ppasw_top.sv
// Function
// R1: Push-pull alternates successive input pulses between outputs A and B.
// R2: Steering configuration is ignored while push-pull mode is selected.
// R3: Sequencer resets when the module is off or on shutdown.
// R4: First pulse after sequencer reset appears on output A.
// R5: Outputs C and D copy A and B with their own inversion.
// R6: Entering shutdown forces safe levels at once, no software action.
// R7: Software setting the shutdown bit forces the shutdown state.
// R8: Without auto restart, shutdown holds while the bit stays set.
// R9: With auto restart, bit clears itself; resumes at next rising data.
// R10: Shutdown bit shows shutdown; hardware and software may set or clear.
// R11: Any enabled active source forces override levels immediately.
// R12: All sources are active low: pin, three timers, two comparators.
// R13: A source counts only when its enable bit is set.
// R14: Sources are level sensitive; release needs removal or disabling.
// R15: One field sets B and D levels, another sets A and C.
// R16: Setting the shutdown bit by any means sets the event flag.
// R17: Every shutdown cause must be gone before any restart.
// R18: Software clears the bit after sources go when auto restart is off.
// R19: After software clear, output resumes at next rising data edge.
// R20: Software clear is ignored while a shutdown condition persists.
// R21: With auto restart, hardware clears the bit once causes are gone.
// R22: Hardware shutdown beats a same-cycle software clear.
`timescale 1ns/1ps
`default_nettype none
`include "ppasw_defines.svh"
module ppasw_top
   import ppasw_pkg::*;
#(
   parameter int NSRC = `PPASW_NSRC
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   input wire logic dataIn,
   input wire logic [NSRC-1:0] srcLowN,
   output logic output_a,
   output logic output_b,
   output logic output_c,
   output logic output_d,
   output logic [3:0] outEn,
   output logic shutdown_event_flag
);
   typedef enum logic [1:0] {RUN, SHUT, WAITEDGE} ppasw_mode_t;
   typedef struct packed {
      ppasw_ctrl_t ctrl;
      ppasw_sdcfg_t sd;
      logic [NSRC-1:0] srcOn;
      logic shut;
      logic flag;
      ppasw_mode_t mode;
      logic phaseB;
      logic dataPrev;
      ppasw_quad_t outs;
      logic [3:0] oe;
      logic [31:0] rdata;
   } ppasw_state_t;

   ppasw_state_t st_r;
   ppasw_state_t st_nxt;
   logic srcActive;
   logic [3:0] ovVal;
   logic [3:0] ovDrv;
   logic [3:0] normal;
   logic [3:0] inv;
   logic [3:0] forcedV;
   logic [7:0] levels;

   // Sources are combined without a register so a fault overrides the
   // outputs on the next edge; a glitch on a source is not filtered out.
   ppasw_src_filter #(.NSRC(NSRC)) i_ppasw_src_filter (
      .srcLowN(srcLowN),
      .source_on_bits(st_r.srcOn),
      .active(srcActive)
   );

   // The edge detector resets to zero, the idle level of the data input,
   // so no false rising edge follows reset.
   wire logic rise = dataIn & ~st_r.dataPrev;
   wire logic wrSd = regWr && regAddr == `PPASW_ADDR_SDCTL;
   wire logic swSet = wrSd && regWdata[`PPASW_SD_SHUT];
   wire logic swClr = wrSd && !regWdata[`PPASW_SD_SHUT];
   wire logic enterShut = (srcActive || swSet) && !st_r.shut;

   // Normal waveform: push-pull alternates, otherwise steered A and C follow the input, B and D its inverse.
   always_comb
   begin
      normal = 4'h0;
      if (st_r.ctrl.enable && st_r.mode == RUN)
      begin
         if (st_r.ctrl.pushPull)
         begin
            // Steering field is deliberately not consulted here.
            normal[3] = dataIn & ~st_r.phaseB; // R1 R2 R4
            normal[2] = dataIn & st_r.phaseB; // R1
            normal[1] = normal[3]; // R5
            normal[0] = normal[2]; // R5
         end
         else
         begin
            normal[3] = dataIn & st_r.ctrl.steer[3];
            normal[2] = ~dataIn & st_r.ctrl.steer[2];
            normal[1] = dataIn & st_r.ctrl.steer[1];
            normal[0] = ~dataIn & st_r.ctrl.steer[0];
         end
      end
   end

   assign inv = {st_r.ctrl.polA, st_r.ctrl.polB,
      st_r.ctrl.out_c_invert, st_r.ctrl.out_d_invert}; // R5
   // A source forces the outputs on the next edge after it appears.
   assign forcedV = {4{st_r.shut | srcActive | swSet}}; // R6 R11
   assign levels = {st_r.sd.override_level_ac, st_r.sd.override_level_bd,
      st_r.sd.override_level_ac, st_r.sd.override_level_bd}; // R15

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_ov
         ppasw_override i_ppasw_override (
            .normal(normal[gi]),
            .invert(inv[gi]),
            .forced(forcedV[gi]),
            .level(levels[2*gi+1:2*gi]),
            .value(ovVal[gi]),
            .drive(ovDrv[gi])
         );
      end
   endgenerate

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.dataPrev = dataIn;
      st_nxt.flag = st_r.flag;
      if (regWr)
      begin
         case (regAddr)
            `PPASW_ADDR_CTRL:
            begin
               st_nxt.ctrl.enable = regWdata[`PPASW_CTRL_EN];
               st_nxt.ctrl.pushPull = regWdata[`PPASW_CTRL_PP];
               st_nxt.ctrl.polA = regWdata[`PPASW_CTRL_POLA];
               st_nxt.ctrl.polB = regWdata[`PPASW_CTRL_POLB];
               st_nxt.ctrl.out_c_invert = regWdata[`PPASW_CTRL_INVC];
               st_nxt.ctrl.out_d_invert = regWdata[`PPASW_CTRL_INVD];
               st_nxt.ctrl.steer =
                  regWdata[`PPASW_CTRL_STEER_HI:`PPASW_CTRL_STEER_LO];
            end
            `PPASW_ADDR_SDCTL:
            begin
               st_nxt.sd.override_level_bd =
                  regWdata[`PPASW_SD_LVBD_HI:`PPASW_SD_LVBD_LO];
               st_nxt.sd.override_level_ac =
                  regWdata[`PPASW_SD_LVAC_HI:`PPASW_SD_LVAC_LO];
               st_nxt.sd.restartEn = regWdata[`PPASW_SD_REN];
            end
            `PPASW_ADDR_SDSRC: st_nxt.srcOn = regWdata[NSRC-1:0]; // R13
            `PPASW_ADDR_STAT:
               // Writing one clears the flag; a new event still wins.
               if (regWdata[`PPASW_ST_FLAG])
                  st_nxt.flag = 1'b0;
            default: st_nxt.rdata = st_r.rdata;
         endcase
      end

      // Shutdown bit bookkeeping.
      // Hardware set is tested first, so it beats a same-cycle clear.
      if (srcActive || swSet)
         st_nxt.shut = 1'b1; // R7 R10 R22
      else if (st_r.shut && swClr && !st_r.sd.restartEn)
         st_nxt.shut = 1'b0; // R18 R20 R17
      else if (st_r.shut && st_r.sd.restartEn)
         st_nxt.shut = 1'b0; // R21 R9 R17
      if (enterShut)
         st_nxt.flag = 1'b1; // R16

      // Leaving shutdown parks in WAITEDGE so a pulse already high at
      // release is not delivered as a runt.
      // Operating mode.
      case (st_r.mode)
         RUN: if (st_nxt.shut) st_nxt.mode = SHUT;
         SHUT: if (!st_nxt.shut) st_nxt.mode = WAITEDGE; // R8
         WAITEDGE:
            if (st_nxt.shut)
               st_nxt.mode = SHUT;
            else if (rise)
               st_nxt.mode = RUN; // R9 R19
         default: st_nxt.mode = SHUT;
      endcase

      // Sequencer advances on each falling input edge.
      if (!st_r.ctrl.enable || st_nxt.shut || st_r.mode != RUN)
         st_nxt.phaseB = 1'b0; // R3
      else if (st_r.dataPrev && !dataIn)
         st_nxt.phaseB = ~st_r.phaseB; // R1 R4

      st_nxt.outs = {ovVal[3], ovVal[2], ovVal[1], ovVal[0]};
      st_nxt.oe = ovDrv;

      st_nxt.rdata = `PPASW_ZERO32;
      if (regRd)
      begin
         case (regAddr)
            `PPASW_ADDR_CTRL:
            begin
               st_nxt.rdata[`PPASW_CTRL_EN] = st_r.ctrl.enable;
               st_nxt.rdata[`PPASW_CTRL_PP] = st_r.ctrl.pushPull;
               st_nxt.rdata[`PPASW_CTRL_POLA] = st_r.ctrl.polA;
               st_nxt.rdata[`PPASW_CTRL_POLB] = st_r.ctrl.polB;
               st_nxt.rdata[`PPASW_CTRL_INVC] = st_r.ctrl.out_c_invert;
               st_nxt.rdata[`PPASW_CTRL_INVD] = st_r.ctrl.out_d_invert;
               st_nxt.rdata[`PPASW_CTRL_STEER_HI:`PPASW_CTRL_STEER_LO] =
                  st_r.ctrl.steer;
            end
            `PPASW_ADDR_SDCTL:
            begin
               st_nxt.rdata[`PPASW_SD_LVBD_HI:`PPASW_SD_LVBD_LO] =
                  st_r.sd.override_level_bd;
               st_nxt.rdata[`PPASW_SD_LVAC_HI:`PPASW_SD_LVAC_LO] =
                  st_r.sd.override_level_ac;
               st_nxt.rdata[`PPASW_SD_REN] = st_r.sd.restartEn;
               st_nxt.rdata[`PPASW_SD_SHUT] = st_r.shut; // R10
            end
            `PPASW_ADDR_SDSRC: st_nxt.rdata[NSRC-1:0] = st_r.srcOn;
            `PPASW_ADDR_STAT:
            begin
               st_nxt.rdata[`PPASW_ST_FLAG] = st_r.flag;
               st_nxt.rdata[`PPASW_ST_PHASE] = st_r.phaseB;
            end
            default: st_nxt.rdata = `PPASW_ZERO32;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         st_r <= '0;
         st_r.mode <= RUN;
      end
      else
         st_r <= st_nxt;
   end

   // Outputs lag the resolver by one cycle since every output is registered.
   assign output_a = st_r.outs.outA;
   assign output_b = st_r.outs.outB;
   assign output_c = st_r.outs.outC;
   assign output_d = st_r.outs.outD;
   assign outEn = st_r.oe;
   assign shutdown_event_flag = st_r.flag;
   assign regRdata = st_r.rdata;

   a_shut_forces: assert property (@(posedge sys_clk) disable iff (rst) // R11
      (srcActive && st_r.sd.override_level_ac == `PPASW_LVL_HIGH)
      |=> output_a && output_c)
      else $error("Override level not applied after source went active");

   a_flag_sets: assert property (@(posedge sys_clk) disable iff (rst) // R16
      (!st_r.shut && srcActive) |=> shutdown_event_flag)
      else $error("Event flag not set on shutdown");

   a_hw_beats_clr: assert property (@(posedge sys_clk) disable iff (rst) // R22
      (srcActive && swClr) |=> st_r.shut)
      else $error("Software clear won over hardware shutdown");

   a_clr_ignored: assert property (@(posedge sys_clk) disable iff (rst) // R20
      (st_r.shut && srcActive) |=> st_r.shut)
      else $error("Shutdown bit cleared while source active");

   a_hold_noren: assert property (@(posedge sys_clk) disable iff (rst) // R8
      (st_r.shut && !st_r.sd.restartEn && !wrSd) |=> st_r.shut)
      else $error("Shutdown dropped without software clear");

   a_auto_clear: assert property (@(posedge sys_clk) disable iff (rst) // R21
      (st_r.shut && st_r.sd.restartEn && !srcActive && !swSet)
      |=> !st_r.shut)
      else $error("Auto restart did not clear shutdown bit");

   a_wait_edge: assert property (@(posedge sys_clk) disable iff (rst) // R19
      (st_r.mode == WAITEDGE && !dataIn) |=> st_r.mode != RUN)
      else $error("Resumed without a rising data edge");

   a_seq_reset: assert property (@(posedge sys_clk) disable iff (rst) // R3
      (!st_r.ctrl.enable || st_r.shut) |=> !st_r.phaseB)
      else $error("Sequencer not reset");

   a_pp_exclusive: assert property (@(posedge sys_clk) disable iff (rst) // R1
      (st_r.ctrl.pushPull && !st_r.shut && !srcActive && !swSet
      && !st_r.ctrl.polA && !st_r.ctrl.polB)
      |=> !(output_a && output_b))
      else $error("Push-pull outputs high together");

   // Checks on output resolution, the sequencer, the shutdown bit, the operating mode and the event flag.
   a_flag_sticky: assert property (@(posedge sys_clk) disable iff (rst) // R16
      (st_r.flag && !(regWr && regAddr == `PPASW_ADDR_STAT
      && regWdata[`PPASW_ST_FLAG])) |=> st_r.flag)
      else $error("Event flag dropped without a clear");

   a_sw_sets: assert property (@(posedge sys_clk) disable iff (rst) // R7
      swSet |=> st_r.shut)
      else $error("Software set did not enter shutdown");

   a_src_holds: assert property (@(posedge sys_clk) disable iff (rst) // R14
      srcActive |=> st_r.shut)
      else $error("Active source did not hold shutdown");

   a_float_bd: assert property (@(posedge sys_clk) disable iff (rst) // R15
      (st_r.shut && st_r.sd.override_level_bd == `PPASW_LVL_FLOAT)
      |=> !outEn[2] && !outEn[0])
      else $error("Float override still drives B or D");

   a_low_ac: assert property (@(posedge sys_clk) disable iff (rst) // R15
      (st_r.shut && st_r.sd.override_level_ac == `PPASW_LVL_LOW)
      |=> !output_a && !output_c)
      else $error("Low override not applied to A and C");

   a_resume_edge: assert property (@(posedge sys_clk) disable iff (rst) // R19
      (st_r.mode == WAITEDGE && rise && !srcActive && !swSet)
      |=> st_r.mode == RUN)
      else $error("Rising data edge did not resume output");

   a_c_follows_a: assert property (@(posedge sys_clk) disable iff (rst) // R5
      (st_r.ctrl.pushPull && !st_r.shut && !srcActive && !swSet && !regWr)
      |=> output_c == (output_a ^ st_r.ctrl.polA ^ st_r.ctrl.out_c_invert))
      else $error("Output C does not follow output A");

   a_d_follows_b: assert property (@(posedge sys_clk) disable iff (rst) // R5
      (st_r.ctrl.pushPull && !st_r.shut && !srcActive && !swSet && !regWr)
      |=> output_d == (output_b ^ st_r.ctrl.polB ^ st_r.ctrl.out_d_invert))
      else $error("Output D does not follow output B");

   a_first_on_a: assert property (@(posedge sys_clk) disable iff (rst) // R4
      (st_r.ctrl.pushPull && !st_r.phaseB && !st_r.shut && !srcActive
      && !swSet && !regWr) |=> output_b == st_r.ctrl.polB)
      else $error("Pulse on B while sequencer points at A");

   a_flag_quiet: assert property (@(posedge sys_clk) disable iff (rst) // R16
      (!st_r.flag && !st_r.shut && !srcActive && !swSet) |=> !st_r.flag)
      else $error("Event flag set without a shutdown");
endmodule
`default_nettype wire

// file: ppasw_defines.svh
`ifndef PPASW_DEFINES_SVH
`define PPASW_DEFINES_SVH
// Register byte addresses.
`define PPASW_ADDR_CTRL 4'h0
`define PPASW_ADDR_SDCTL 4'h4
`define PPASW_ADDR_SDSRC 4'h8
`define PPASW_ADDR_STAT 4'hC
// Control register fields.
`define PPASW_CTRL_EN 0
`define PPASW_CTRL_PP 1
`define PPASW_CTRL_POLA 2
`define PPASW_CTRL_POLB 3
`define PPASW_CTRL_INVC 4
`define PPASW_CTRL_INVD 5
`define PPASW_CTRL_STEER_LO 8
`define PPASW_CTRL_STEER_HI 11
// Shutdown control fields.
`define PPASW_SD_LVBD_LO 2
`define PPASW_SD_LVBD_HI 3
`define PPASW_SD_LVAC_LO 4
`define PPASW_SD_LVAC_HI 5
`define PPASW_SD_REN 6
`define PPASW_SD_SHUT 7
// Status fields.
`define PPASW_ST_FLAG 0
`define PPASW_ST_PHASE 1
// Override level encodings.
`define PPASW_LVL_INACT 2'h0
`define PPASW_LVL_FLOAT 2'h1
`define PPASW_LVL_LOW 2'h2
`define PPASW_LVL_HIGH 2'h3
`define PPASW_NSRC 6
`define PPASW_ZERO32 32'h0000_0000
`endif

// file: ppasw_pkg.sv
package ppasw_pkg;
   typedef struct packed {
      logic enable;
      logic pushPull;
      logic polA;
      logic polB;
      logic out_c_invert;
      logic out_d_invert;
      logic [3:0] steer;
   } ppasw_ctrl_t;
   typedef struct packed {
      logic [1:0] override_level_bd;
      logic [1:0] override_level_ac;
      logic restartEn;
   } ppasw_sdcfg_t;
   typedef struct packed {
      logic outA;
      logic outB;
      logic outC;
      logic outD;
   } ppasw_quad_t;
endpackage

// file: ppasw_override.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppasw_defines.svh"
// Resolves one output: its normal level, or the forced safe level.
module ppasw_override
   import ppasw_pkg::*;
(
   input wire logic normal,
   input wire logic invert,
   input wire logic forced,
   input wire logic [1:0] level,
   output logic value,
   output logic drive
);
   always_comb
   begin
      value = normal ^ invert;
      drive = 1'b1;
      if (forced)
      begin
         case (level)
            `PPASW_LVL_INACT: value = invert;
            `PPASW_LVL_FLOAT:
            begin
               value = 1'b0;
               drive = 1'b0;
            end
            `PPASW_LVL_LOW: value = 1'b0;
            `PPASW_LVL_HIGH: value = 1'b1;
            default: value = 1'b0;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: ppasw_src_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppasw_defines.svh"
// Combines active-low, individually enabled shutdown sources into one level.
module ppasw_src_filter
   import ppasw_pkg::*;
#(
   parameter int NSRC = `PPASW_NSRC
)
(
   input wire logic [NSRC-1:0] srcLowN,
   input wire logic [NSRC-1:0] source_on_bits,
   output logic active
);
   assign active = |(~srcLowN & source_on_bits); // R12 R13 R14
endmodule
`default_nettype wire

// file: ppasw_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
// Power stage: floated gate inputs are pulled low, and a fault is reported
// on an active-low line.
module ppasw_stage_model
(
   input wire logic sys_clk,
   input wire logic [3:0] drv,
   input wire logic [3:0] outEn,
   input wire logic faultReq,
   output logic faultLowN,
   output logic [3:0] padLevel,
   output logic shootThrough
);
   assign padLevel = drv & outEn;
   assign faultLowN = !faultReq;
   initial shootThrough = 1'b0;
   // Both switches of one half-bridge on at once would short the supply.
   always @(posedge sys_clk)
   begin
      if (padLevel[3] && padLevel[2])
      begin
         shootThrough <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: ppasw_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module ppasw_top_test;
   import ppasw_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdata;
   logic dataIn = 1'b0;
   logic [5:1] srcHi = 5'h1F;
   logic faultReq = 1'b0;
   logic faultLowN;
   logic output_a, output_b, output_c, output_d;
   logic [3:0] outEn, padLevel;
   logic shutdown_event_flag, shootThrough;
   logic [3:0] q;
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;
   always #50 sys_clk = !sys_clk;
   ppasw_top i_ppasw_top (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .dataIn(dataIn),
      .srcLowN({srcHi, faultLowN}), .output_a(output_a),
      .output_b(output_b), .output_c(output_c), .output_d(output_d),
      .outEn(outEn), .shutdown_event_flag(shutdown_event_flag));
   ppasw_stage_model i_ppasw_stage_model (.sys_clk(sys_clk),
      .drv({output_a, output_b, output_c, output_d}), .outEn(outEn),
      .faultReq(faultReq), .faultLowN(faultLowN), .padLevel(padLevel),
      .shootThrough(shootThrough));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_count++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen,
            exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      tick(1);
      regWr <= 1'b0;
      tick(1);
   endtask
   // Read data stand only in the cycle after the strobe; sample mid-cycle.
   task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
      regAddr <= a;
      regRd <= 1'b1;
      tick(1);
      regRd <= 1'b0;
      @(negedge sys_clk);
      chk(regRdata, exp);
      tick(1);
   endtask
   task automatic pulse(output logic [3:0] qv);
      dataIn <= 1'b1;
      tick(2);
      @(negedge sys_clk);
      qv = {output_a, output_b, output_c, output_d};
      tick(1);
      dataIn <= 1'b0;
      tick(3);
   endtask
   // Steering is set to all outputs; push-pull must ignore it.
   task automatic t_push_pull();
      wr(4'h0, 32'h0000_0F13);
      pulse(q);
      chk(q, 4'h8);
      rdchk(4'hC, 32'h0000_0002);
      pulse(q);
      chk(q, 4'h7);
      pulse(q);
      chk(q, 4'h8);
   endtask
   task automatic t_soft_shutdown();
      wr(4'h4, 32'h0000_00B4);
      tick(2);
      chk({output_a, output_b, output_c, output_d}, 4'hA);
      chk(outEn, 4'hA);
      chk(padLevel, 4'hA);
      chk(shutdown_event_flag, 1'b1);
      rdchk(4'hC, 32'h0000_0001);
      dataIn <= 1'b1;
      wr(4'h4, 32'h0000_0024);
      rdchk(4'h4, 32'h0000_0024);
      chk(output_a, 1'b0);
      dataIn <= 1'b0;
      tick(2);
      pulse(q);
      chk(q, 4'h8);
      wr(4'hC, 32'h0000_0001);
      rdchk(4'hC, 32'h0000_0002);
      rdchk(4'h2, 32'h0000_0000);
   endtask
   task automatic t_hw_source();
      srcHi[2] <= 1'b0;
      tick(3);
      rdchk(4'h4, 32'h0000_0024);
      wr(4'h8, 32'h0000_0004);
      rdchk(4'h4, 32'h0000_00A4);
      chk(padLevel, 4'h0);
      wr(4'h4, 32'h0000_0024);
      rdchk(4'h4, 32'h0000_00A4);
      srcHi[2] <= 1'b1;
      tick(3);
      rdchk(4'h4, 32'h0000_00A4);
      wr(4'h4, 32'h0000_0024);
      rdchk(4'h4, 32'h0000_0024);
      chk(shutdown_event_flag, 1'b1);
   endtask
   task automatic t_auto_restart();
      wr(4'h8, 32'h0000_0001);
      wr(4'h4, 32'h0000_0064);
      faultReq <= 1'b1;
      tick(3);
      rdchk(4'h4, 32'h0000_00E4);
      faultReq <= 1'b0;
      tick(3);
      rdchk(4'h4, 32'h0000_0064);
      pulse(q);
      chk(q, 4'h8);
      chk(outEn, 4'hF);
   endtask
   // A fault arrives in the very cycle that software asks to clear.
   task automatic t_clear_race();
      wr(4'h4, 32'h0000_00A4);
      faultReq <= 1'b1;
      wr(4'h4, 32'h0000_0024);
      rdchk(4'h4, 32'h0000_00A4);
      faultReq <= 1'b0;
      tick(2);
      wr(4'h4, 32'h0000_0024);
      rdchk(4'h4, 32'h0000_0024);
   endtask
   // Outside push-pull the steering routes data; disabling resets phase.
   task automatic t_steer_disable();
      wr(4'h0, 32'h0000_0F01);
      pulse(q);
      chk(q, 4'hA);
      chk({output_a, output_b, output_c, output_d}, 4'h5);
      rdchk(4'hC, 32'h0000_0003);
      wr(4'h0, 32'h0000_0000);
      rdchk(4'hC, 32'h0000_0001);
   endtask
   initial
   begin
      tick(5);
      rst <= 1'b0;
      tick(1);
      t_push_pull();
      t_soft_shutdown();
      t_hw_source();
      t_auto_restart();
      t_clear_race();
      t_steer_disable();
      chk(shootThrough, 1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire
